// ===== core/siu_params.svh
// Constants of the system integration unit register bank
`ifndef SIU_PARAMS_SVH
`define SIU_PARAMS_SVH

`define SIU_AW            5
`define SIU_DW            16

// Word offsets
`define SIU_A_CTRL        5'h00
`define SIU_A_RSTAT       5'h01
`define SIU_A_SCR0        5'h02
`define SIU_A_SCR3        5'h05
`define SIU_A_IDHI        5'h06
`define SIU_A_IDLO        5'h07
`define SIU_A_PWR         5'h08
`define SIU_A_CLKOUT      5'h0A
`define SIU_A_PCR         5'h0B
`define SIU_A_PCE0        5'h0C
`define SIU_A_PCE1        5'h0D
`define SIU_A_SD0         5'h0E
`define SIU_A_SD1         5'h0F
`define SIU_A_IOSHI       5'h10
`define SIU_A_IOSLO       5'h11
`define SIU_A_PROT        5'h12
`define SIU_A_GPSA0       5'h13
`define SIU_A_GPSB0       5'h15
`define SIU_A_GPSB1       5'h16
`define SIU_A_IPS0        5'h18
`define SIU_A_IPS1        5'h19
`define SIU_A_IPS2        5'h1A

// Writable bit masks of the plain configuration words
`define SIU_M_PWR         16'h0003
`define SIU_M_CLKOUT      16'h03FF
`define SIU_M_PCR         16'h7000
`define SIU_M_PCE0        16'hF455
`define SIU_M_PCE1        16'h100F
`define SIU_M_IOSHI       16'h0003
`define SIU_M_IOSLO       16'h03C0
`define SIU_M_PROT        16'h000F
`define SIU_M_GPSA0       16'h1F00
`define SIU_M_GPSB0       16'h7FF5
`define SIU_M_GPSB1       16'h0001
`define SIU_M_IPS0        16'h29FF
`define SIU_M_IPS1        16'h0007
`define SIU_M_IPS2        16'h1110

// Control word bit positions
`define SIU_B_DBG         5
`define SIU_B_SOFTWARE_RESET_TRIGGER       4
`define SIU_B_LOCK        1

// Reset values; identity words are arbitrary neutral values
`define SIU_CTRL_RST      16'h0000
`define SIU_RSTAT_POR     16'h0004
`define SIU_ID_HI         16'h0A5A
`define SIU_ID_LO         16'h1C3D

`endif

// ===== core/siu_pkg.sv
// Types of the system integration unit register bank
package siu_pkg;

  // Control word as stored
  typedef struct packed {
    logic [9:0] zero;        // Bits 15-6, always zero
    logic       dbg_on;      // debug_clock_always_on
    logic       software_reset_trigger;       // software_reset_trigger, never stored
    logic [1:0] stop_gate;   // {lock, block}
    logic [1:0] wait_gate;   // {lock, block}
  } siu_ctrl_t;

  // Reset cause word
  typedef struct packed {
    logic [8:0] zero;                    // Bits 15-7
    logic       cause_software;
    logic       cause_watchdog_timeout;
    logic       cause_reference_loss;
    logic       cause_external_pin;
    logic       cause_power_on;
    logic [1:0] zero_lo;
  } siu_rstat_t;

endpackage

// ===== core/siu_regs.sv
// System integration unit control and status register bank
`timescale 1ns/10ps
`include "siu_params.svh"

module siu_regs (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,          // Power-on reset
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic        i_ext_rst,        // External pin reset
  input  wire logic        i_ref_loss,       // Watchdog reference loss
  input  wire logic        i_wdog_timeout,   // Watchdog time-out
  input  wire logic        i_tap_enabled,    // Core test port enabled
  input  wire logic        i_core_stop,      // Core executes stop
  input  wire logic        i_core_wait,      // Core executes wait
  output logic [15:0]      o_rd_data,
  output logic             o_chip_reset,
  output logic             o_debug_clk_en,
  output logic             o_stop_enter,
  output logic             o_wait_enter,
  output logic [31:0]      o_periph_clk_en,
  output logic [31:0]      o_stop_clk_keep,
  output logic             o_regulator_standby
);

  // Writable mask of a plain configuration word, zero if unmapped
  function automatic logic [15:0] siu_wmask(input logic [4:0] a);
    case (a)
      `SIU_A_PWR:    siu_wmask = `SIU_M_PWR;
      `SIU_A_CLKOUT: siu_wmask = `SIU_M_CLKOUT;
      `SIU_A_PCR:    siu_wmask = `SIU_M_PCR;
      `SIU_A_PCE0:   siu_wmask = `SIU_M_PCE0;
      `SIU_A_PCE1:   siu_wmask = `SIU_M_PCE1;
      `SIU_A_SD0:    siu_wmask = `SIU_M_PCE0;
      `SIU_A_SD1:    siu_wmask = `SIU_M_PCE1;
      `SIU_A_IOSHI:  siu_wmask = `SIU_M_IOSHI;
      `SIU_A_IOSLO:  siu_wmask = `SIU_M_IOSLO;
      `SIU_A_PROT:   siu_wmask = `SIU_M_PROT;
      `SIU_A_GPSA0:  siu_wmask = `SIU_M_GPSA0;
      `SIU_A_GPSB0:  siu_wmask = `SIU_M_GPSB0;
      `SIU_A_GPSB1:  siu_wmask = `SIU_M_GPSB1;
      `SIU_A_IPS0:   siu_wmask = `SIU_M_IPS0;
      `SIU_A_IPS1:   siu_wmask = `SIU_M_IPS1;
      `SIU_A_IPS2:   siu_wmask = `SIU_M_IPS2;
      default:       siu_wmask = 16'h0000;
    endcase
  endfunction

  siu_pkg::siu_ctrl_t  ctrl_reg;          // Control word
  siu_pkg::siu_ctrl_t  ctrl_next;
  siu_pkg::siu_rstat_t rstat_reg;         // Reset cause word
  siu_pkg::siu_rstat_t rstat_next;
  logic [15:0]         scr_reg [0:3];     // Scratch words, POR only
  logic [15:0]         cfg_reg [0:31];    // Plain configuration words
  logic                software_reset_trigger_reg;         // Pending software reset
  logic [15:0]         rd_next;

  // Decode
  wire ctrl_wr  = i_wr_en && (i_addr == `SIU_A_CTRL);
  wire scr_hit  = (i_addr >= `SIU_A_SCR0) && (i_addr <= `SIU_A_SCR3);
  wire [1:0] scr_idx = 2'(i_addr - `SIU_A_SCR0);
  wire [15:0] wmask  = siu_wmask(i_addr);
  // A locked regulator field refuses writes like the gate fields
  wire pwr_lock = cfg_reg[`SIU_A_PWR][`SIU_B_LOCK];
  wire cfg_wr   = i_wr_en && (wmask != 16'h0000) &&
                  !((i_addr == `SIU_A_PWR) && pwr_lock);

  // Any system reset source; power-on is the async reset itself
  wire sys_rst_evt = i_ext_rst | i_ref_loss | i_wdog_timeout | software_reset_trigger_reg;

  // Control word next value
  always_comb begin
    ctrl_next = ctrl_reg;
    if (sys_rst_evt) begin
      ctrl_next = siu_pkg::siu_ctrl_t'(`SIU_CTRL_RST);
    end else if (ctrl_wr) begin
      // Upper bits stay zero whatever software writes
      ctrl_next.dbg_on = i_wr_data[`SIU_B_DBG];
      if (!ctrl_reg.stop_gate[1]) begin
        ctrl_next.stop_gate = i_wr_data[3:2];
      end
      if (!ctrl_reg.wait_gate[1]) begin
        ctrl_next.wait_gate = i_wr_data[1:0];
      end
    end
  end

  // Reset cause: only the highest simultaneous source is kept
  always_comb begin
    rstat_next = rstat_reg;
    if (sys_rst_evt) begin
      rstat_next = '0;
      if (i_ext_rst) begin
        rstat_next.cause_external_pin = 1'b1;
      end else if (i_ref_loss) begin
        rstat_next.cause_reference_loss = 1'b1;
      end else if (i_wdog_timeout) begin
        rstat_next.cause_watchdog_timeout = 1'b1;
      end else begin
        rstat_next.cause_software = 1'b1;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_next = 16'h0000;
    if (i_rd_en) begin
      if (i_addr == `SIU_A_CTRL) begin
        rd_next = 16'(ctrl_reg);
      end else if (i_addr == `SIU_A_RSTAT) begin
        rd_next = 16'(rstat_reg);
      end else if (scr_hit) begin
        rd_next = scr_reg[scr_idx];
      end else if (i_addr == `SIU_A_IDHI) begin
        rd_next = `SIU_ID_HI;
      end else if (i_addr == `SIU_A_IDLO) begin
        rd_next = `SIU_ID_LO;
      end else begin
        rd_next = cfg_reg[i_addr] & wmask;
      end
    end
  end

  // Control, status and reset pulse
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg     <= siu_pkg::siu_ctrl_t'(`SIU_CTRL_RST);
      rstat_reg    <= siu_pkg::siu_rstat_t'(`SIU_RSTAT_POR);
      software_reset_trigger_reg    <= 1'b0;
      o_chip_reset <= 1'b0;
    end else begin
      ctrl_reg     <= ctrl_next;
      rstat_reg    <= rstat_next;
      // Taken from the write, never stored in the word
      software_reset_trigger_reg    <= ctrl_wr && i_wr_data[`SIU_B_SOFTWARE_RESET_TRIGGER] && !sys_rst_evt;
      o_chip_reset <= sys_rst_evt;
    end
  end

  // Scratch words ignore every reset but power-on
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 4; i++) begin
        scr_reg[i] <= 16'h0000;
      end
    end else if (i_wr_en && scr_hit) begin
      scr_reg[scr_idx] <= i_wr_data;
    end
  end

  // Plain configuration words, cleared by any system reset
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 32; i++) begin
        cfg_reg[i] <= 16'h0000;
      end
    end else if (sys_rst_evt) begin
      for (int i = 0; i < 32; i++) begin
        cfg_reg[i] <= 16'h0000;
      end
    end else if (cfg_wr) begin
      cfg_reg[i_addr] <= i_wr_data & wmask;
    end
  end

  // Read data and low-power / debug outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data      <= 16'h0000;
      o_debug_clk_en <= 1'b0;
      o_stop_enter   <= 1'b0;
      o_wait_enter   <= 1'b0;
    end else begin
      o_rd_data      <= rd_next;
      // Free-running only when forced; otherwise follows the TAP
      o_debug_clk_en <= ctrl_reg.dbg_on | i_tap_enabled;
      o_stop_enter   <= i_core_stop & ~ctrl_reg.stop_gate[0];
      o_wait_enter   <= i_core_wait & ~ctrl_reg.wait_gate[0];
    end
  end

  // Gate enables come straight from the stored words; the clock
  // gate cells themselves sit beside each peripheral
  assign o_periph_clk_en = {cfg_reg[`SIU_A_PCE1],
                            cfg_reg[`SIU_A_PCE0]};
  assign o_stop_clk_keep = {cfg_reg[`SIU_A_SD1], cfg_reg[`SIU_A_SD0]};
  assign o_regulator_standby = cfg_reg[`SIU_A_PWR][0];

  // Checks
  // Software reset write, then the pending flag, then the request
  sequence s_software_reset_trigger_write;
    ctrl_wr && i_wr_data[`SIU_B_SOFTWARE_RESET_TRIGGER] && !sys_rst_evt;
  endsequence

  sequence s_reset_pulse;
    ##1 software_reset_trigger_reg ##1 o_chip_reset;
  endsequence

  chk_software_reset_trigger_reset_pulse: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    s_software_reset_trigger_write |-> s_reset_pulse)
    else $error("Software reset write gave no chip reset");

  chk_software_reset_trigger_reads_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_rd_en && i_addr == `SIU_A_CTRL) |=> !o_rd_data[`SIU_B_SOFTWARE_RESET_TRIGGER])
    else $error("Software reset bit read back as one");

  chk_debug_clock_sel: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (!ctrl_reg.dbg_on && !i_tap_enabled) |=> !o_debug_clk_en)
    else $error("Debug clock on without TAP or force");

  chk_stop_gate_block: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_core_stop |=> (o_stop_enter == !$past(ctrl_reg.stop_gate[0])))
    else $error("Stop entry disagrees with gate bit");

  chk_stop_gate_lock: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (ctrl_reg.stop_gate[1] && !sys_rst_evt) |=> $stable(ctrl_reg.stop_gate))
    else $error("Locked stop gate field changed");

  chk_wait_gate_lock: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (ctrl_reg.wait_gate[1] && !sys_rst_evt) |=> $stable(ctrl_reg.wait_gate))
    else $error("Locked wait gate field changed");

  chk_cause_priority: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ext_rst && (i_ref_loss || i_wdog_timeout)) |=>
      (rstat_reg == siu_pkg::siu_rstat_t'(16'h0008)))
    else $error("Reset cause not the highest one");

  chk_scratch_survives: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (sys_rst_evt && !(i_wr_en && scr_hit)) |=>
      ($stable(scr_reg[0]) && $stable(scr_reg[1]) &&
       $stable(scr_reg[2]) && $stable(scr_reg[3])))
    else $error("Scratch word lost on system reset");

  chk_unmapped_write: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_wr_en && i_addr == 5'h09 && !sys_rst_evt) |=>
      ($stable(ctrl_reg) && $stable(o_periph_clk_en)))
    else $error("Unmapped write changed state");

  chk_clock_enable_wr: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_wr_en && i_addr == `SIU_A_PCE0 && !sys_rst_evt) |=>
      (o_periph_clk_en[15:0] == ($past(i_wr_data) & `SIU_M_PCE0)))
    else $error("Clock enable did not follow write");

  // Upper control bits never read back as one
  chk_ctrl_upper_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_rd_en && i_addr == `SIU_A_CTRL) |=> (o_rd_data[15:6] == 10'h000))
    else $error("Control word upper bits read back as one");

  // Force bit or enabled TAP must keep the debug clock running
  chk_debug_clock_on: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (ctrl_reg.dbg_on || i_tap_enabled) |=> o_debug_clk_en)
    else $error("Debug clock off while forced or TAP on");

  // Every system reset cause gives one chip reset request
  chk_reset_request: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    sys_rst_evt |=> o_chip_reset)
    else $error("System reset cause gave no chip reset");

  // Wait entry follows the low gate bit, like stop entry
  chk_wait_gate_block: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_core_wait |=> (o_wait_enter == !$past(ctrl_reg.wait_gate[0])))
    else $error("Wait entry disagrees with gate bit");

  // A lone software cause is flagged as a software reset
  chk_cause_software: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (software_reset_trigger_reg && !i_ext_rst && !i_ref_loss && !i_wdog_timeout) |=>
      (rstat_reg == siu_pkg::siu_rstat_t'(16'h0040)))
    else $error("Software reset not flagged as the cause");

  // Only the latest cause stands after a system reset
  chk_cause_onehot: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    sys_rst_evt |=> $onehot(16'(rstat_reg)))
    else $error("Reset status shows more than one cause");

  // Upper enable word drives the upper half of the gate enables
  chk_clock_enable_hi: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_wr_en && i_addr == `SIU_A_PCE1 && !sys_rst_evt) |=>
      (o_periph_clk_en[31:16] == ($past(i_wr_data) & `SIU_M_PCE1)))
    else $error("Upper clock enables did not follow write");

endmodule // siu_regs

// ===== tb/siu_core_model.sv
// Core-side model that issues stop and wait instructions
`timescale 1ns/10ps

module siu_core_model (
  input  wire logic i_clk_sys,
  input  wire logic i_go_stop,   // Bench asks for a stop instruction
  input  wire logic i_go_wait,   // Bench asks for a wait instruction
  output logic      o_core_stop,
  output logic      o_core_wait
);
  // Registered one-cycle pulses, as a core decode stage would give them
  always_ff @(posedge i_clk_sys) begin
    o_core_stop <= i_go_stop;
    o_core_wait <= i_go_wait;
  end
endmodule // siu_core_model

// ===== tb/siu_regs_tb_top.sv
// Self-checking bench of the system integration register bank
`timescale 1ns/10ps
`include "siu_params.svh"

module siu_regs_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic [4:0]  addr    = 5'h00;
  logic [15:0] wr_data = 16'h0000;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic        ext_rst = 1'b0;
  logic        ref_ls  = 1'b0;
  logic        wdog    = 1'b0;
  logic        tap_en  = 1'b0;
  logic        go_stop = 1'b0;
  logic        go_wait = 1'b0;
  logic        core_stop, core_wait, chip_rst, dbg_en, stop_ent, wait_ent;
  logic [15:0] rd_data;
  logic [31:0] pclk_en, stop_keep;
  logic        reg_stby;
  logic [15:0] exp_q[$];   // Expected read data, oldest first
  logic        rd_seen = 1'b0;
  logic        hs, hw, hr; // Pulses seen in a watch window
  integer      failures = 0;
  integer      total_checks = 0;
  integer      cyc = 0;
  integer      seed = 32'h2D27;
  logic [15:0] rnd;

  always #10 clk_sys = ~clk_sys;

  siu_core_model i_core (.i_clk_sys(clk_sys), .i_go_stop(go_stop),
    .i_go_wait(go_wait), .o_core_stop(core_stop), .o_core_wait(core_wait));

  siu_regs i_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_addr(addr),
    .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_ext_rst(ext_rst), .i_ref_loss(ref_ls), .i_wdog_timeout(wdog),
    .i_tap_enabled(tap_en), .i_core_stop(core_stop),
    .i_core_wait(core_wait), .o_rd_data(rd_data), .o_chip_reset(chip_rst),
    .o_debug_clk_en(dbg_en), .o_stop_enter(stop_ent),
    .o_wait_enter(wait_ent), .o_periph_clk_en(pclk_en),
    .o_stop_clk_keep(stop_keep), .o_regulator_standby(reg_stby));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    // A read whose data never came back counts against the run
    if (exp_q.size() != 0) failures++;
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One-cycle write strobe; a gap cycle follows so strobes never merge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  // Read strobe; the expectation waits in the queue for the monitor
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    rd_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen)
      check(32'(rd_data), 32'(exp_q.pop_front()));
    rd_seen <= rd_en;
  end

  // Collect mode and reset pulses over n edges
  task automatic watch(input int n);
    hs = 1'b0;
    hw = 1'b0;
    hr = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      hs = hs | stop_ent;
      hw = hw | wait_ent;
      hr = hr | chip_rst;
    end
  endtask

  // One core instruction, then the expected entry pulses
  task automatic mode(input logic s, input logic es, input logic ew);
    @(posedge clk_sys);
    go_stop <= s;
    go_wait <= !s;
    @(posedge clk_sys);
    go_stop <= 1'b0;
    go_wait <= 1'b0;
    watch(4);
    check(32'(hs), 32'(es));
    check(32'(hw), 32'(ew));
  endtask

  // One cycle of system reset causes, then the status word
  task automatic cause(input logic [2:0] c, input logic [15:0] st);
    @(posedge clk_sys);
    {ext_rst, ref_ls, wdog} <= c;
    @(posedge clk_sys);
    {ext_rst, ref_ls, wdog} <= 3'b000;
    watch(3);
    check(32'(hr), 32'h1);
    rd(`SIU_A_RSTAT, st);
  endtask

  // Hang guard, far above the roughly 160 cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      print_verdict;
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`SIU_A_CTRL, `SIU_CTRL_RST);
    rd(`SIU_A_RSTAT, `SIU_RSTAT_POR);
    rd(`SIU_A_IDHI, `SIU_ID_HI);
    rd(`SIU_A_IDLO, `SIU_ID_LO);
    wr(`SIU_A_CTRL, 16'hFFC0);
    rd(`SIU_A_CTRL, 16'h0000);
    wr(`SIU_A_CTRL, 16'h0020);
    rd(`SIU_A_CTRL, 16'h0020);
    check(32'(dbg_en), 32'h1);
    wr(`SIU_A_CTRL, 16'h0000);
    watch(2);
    check(32'(dbg_en), 32'h0);
    tap_en <= 1'b1;
    watch(2);
    check(32'(dbg_en), 32'h1);
    mode(1'b1, 1'b1, 1'b0);
    mode(1'b0, 1'b0, 1'b1);
    wr(`SIU_A_CTRL, 16'h0005);
    mode(1'b1, 1'b0, 1'b0);
    mode(1'b0, 1'b0, 1'b0);
    // Locked but unblocked: the later blocking write must bounce
    wr(`SIU_A_CTRL, 16'h000A);
    wr(`SIU_A_CTRL, 16'h0005);
    rd(`SIU_A_CTRL, 16'h000A);
    mode(1'b1, 1'b1, 1'b0);
    // Regulator word: standby plus lock, then a refused clear
    wr(`SIU_A_PWR, 16'h0003);
    wr(`SIU_A_PWR, 16'h0000);
    watch(1);
    check(32'(reg_stby), 32'h1);
    rd(`SIU_A_PWR, 16'h0003);
    rnd = 16'($random(seed));
    wr(`SIU_A_SCR0, rnd);
    cause(3'b110, 16'h0008);
    cause(3'b011, 16'h0010);
    cause(3'b001, 16'h0020);
    rd(`SIU_A_SCR0, rnd);
    rd(`SIU_A_CTRL, 16'h0000);
    wr(`SIU_A_CTRL, 16'h0001);
    rd(`SIU_A_CTRL, 16'h0001);
    wr(`SIU_A_CTRL, 16'h0010);
    watch(4);
    check(32'(hr), 32'h1);
    rd(`SIU_A_RSTAT, 16'h0040);
    rd(`SIU_A_CTRL, 16'h0000);
    wr(5'h09, 16'hFFFF);
    rd(5'h09, 16'h0000);
    wr(`SIU_A_RSTAT, 16'hFFFF);
    rd(`SIU_A_RSTAT, 16'h0040);
    repeat (3) begin
      rnd = 16'($random(seed));
      wr(`SIU_A_PCE0, rnd);
      wr(`SIU_A_PCE1, ~rnd);
      wr(`SIU_A_SD0, rnd);
      wr(`SIU_A_SD1, ~rnd);
      watch(1);
      check(pclk_en, {~rnd & `SIU_M_PCE1, rnd & `SIU_M_PCE0});
      check(stop_keep, {~rnd & `SIU_M_PCE1, rnd & `SIU_M_PCE0});
    end
    // Power-on reset in mid-run wipes the scratch word
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`SIU_A_SCR0, 16'h0000);
    rd(`SIU_A_RSTAT, `SIU_RSTAT_POR);
    repeat (3) @(posedge clk_sys);
    print_verdict;
  end
endmodule // siu_regs_tb_top
